//--- hw/emb_bus.sv
`timescale 1ns/1ps
`include "emb_map.svh"
// Operation
// - Ports one to three: a latch one gives weak pullup, pin readable.
// - Alternate function works only with its latch at one; zero forces low.
// - Port three carries serial, interrupt, counter, write and read functions.
// - External fetches and wide data accesses put the high address on port two.
// - Narrow data accesses keep the port two latch on port two.
// - Program strobe once per six periods on external fetch, skipped for data.
// - Program strobe stays high during internal code execution.
// - Address latch strobe every six periods except during data accesses; none in verify mode.
// - Select high: code below 4096 is internal; low: every fetch external.
// - Port zero is open drain; latch one floats for input.
// - Port zero multiplexes low address and data with strong drive.
// - Write strobe latches port zero byte; memory drives only under read or program strobe.
// - Oscillator is divided by two before the internal state sequencing.
// - Verification: port one gives address, port zero outputs code open drain.
module emb_bus (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_CLK_EN,
  // Request stream from the core
  input wire logic I_REQ_VALID,
  output logic O_REQ_READY,
  input wire logic [1:0] I_REQ_KIND,
  input wire logic I_REQ_WIDE,
  input wire logic [15:0] I_REQ_ADDR,
  input wire logic [7:0] I_REQ_WDATA,
  input wire logic [7:0] I_ROM_DATA,
  // Answer to the core
  output logic O_RESP_VALID,
  output logic [7:0] O_RESP_DATA,
  output logic O_RESP_EXTERNAL,
  // Port latches from the core
  input wire logic [7:0] I_P0_LATCH,
  input wire logic [7:0] I_P1_LATCH,
  input wire logic [7:0] I_P2_LATCH,
  input wire logic [7:0] I_P3_LATCH,
  input wire logic I_SERIAL_TXD,
  // Program verification
  input wire logic I_VERIFY_MODE,
  input wire logic [7:0] I_VERIFY_CODE,
  output logic [7:0] O_VERIFY_ADDR,
  // Control pins
  input wire logic I_RESET_PIN,
  input wire logic I_EXTERNAL_FETCH_SELECT_N,
  output logic O_ADDRESS_LATCH_STROBE,
  output logic O_PROGRAM_STORE_STROBE_N,
  output logic O_CORE_RESET,
  // Port pins
  input wire logic [7:0] I_MUXED_ADDR_DATA_PORT,
  output logic [7:0] O_MUXED_ADDR_DATA_PORT,
  output logic [7:0] O_MUXED_ADDR_DATA_PORT_OE,
  input wire logic [7:0] I_GENERAL_PORT_ONE,
  output logic [7:0] O_GENERAL_PORT_ONE,
  output logic [7:0] O_GENERAL_PORT_ONE_OE,
  input wire logic [7:0] I_HIGH_ADDRESS_PORT,
  output logic [7:0] O_HIGH_ADDRESS_PORT,
  output logic [7:0] O_HIGH_ADDRESS_PORT_OE,
  input wire logic [7:0] I_ALTERNATE_FUNCTION_PORT,
  output logic [7:0] O_ALTERNATE_FUNCTION_PORT,
  output logic [7:0] O_ALTERNATE_FUNCTION_PORT_OE,
  // Synchronised port levels and alternate inputs
  output logic [7:0] O_P0_IN,
  output logic [7:0] O_P1_IN,
  output logic [7:0] O_P2_IN,
  output logic [7:0] O_P3_IN,
  output logic O_SERIAL_RXD,
  output logic O_EXTERNAL_IRQ_ZERO_N,
  output logic O_EXTERNAL_IRQ_ONE_N,
  output logic O_COUNTER_ZERO_INPUT,
  output logic O_COUNTER_ONE_INPUT
);
  typedef struct packed {
    emb_pkg::emb_state_t st;
    logic ph;
    logic [2:0] stage;
    logic busy;
    logic ext;
    logic wide;
    logic [1:0] kind;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] p0_q1;
    logic [7:0] p0_q2;
    logic [7:0] p1_q1;
    logic [7:0] p1_q2;
    logic [7:0] p2_q1;
    logic [7:0] p2_q2;
    logic [7:0] p3_q1;
    logic [7:0] p3_q2;
    logic ea_q1;
    logic ea_q2;
    logic rp_q1;
    logic rp_q2;
    logic [4:0] rst_cnt;
    logic core_rst;
    logic ale;
    logic program_store_strobe_n_n;
    logic [7:0] p0_o;
    logic [7:0] p0_oe;
    logic [7:0] p1_o;
    logic [7:0] p1_oe;
    logic [7:0] p2_o;
    logic [7:0] p2_oe;
    logic [7:0] p3_o;
    logic [7:0] p3_oe;
    logic resp_v;
    logic [7:0] resp_d;
    logic resp_ext;
  } emb_regs_t;

  emb_regs_t r;
  emb_regs_t n;
  logic [3:0] p;
  logic slot_end;
  logic pop;
  logic f_valid;
  logic [`EMB_REQ_W-1:0] f_data;
  logic [1:0] f_kind;
  logic f_wide;
  logic [15:0] f_addr;
  logic [7:0] f_wdata;
  logic [7:0] alt;
  logic [7:0] p3_val;

  function automatic logic in_win(input logic [3:0] idx, input logic [3:0] lo,
                                  input logic [3:0] hi);
    in_win = (idx >= lo) && (idx <= hi);
  endfunction

  // A quasi-bidirectional bit drives only its zeros; its ones are left to the weak pullup.
  function automatic logic [7:0] quasi_oe(input logic [7:0] v);
    quasi_oe = ~v;
  endfunction

  emb_fifo #(
    .W(`EMB_REQ_W),
    .D(`EMB_FIFO_DEPTH)
  ) u_req_fifo (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_clk_en(I_CLK_EN),
    .i_in_valid(I_REQ_VALID),
    .o_in_ready(O_REQ_READY),
    .i_in_data({I_REQ_KIND, I_REQ_WIDE, I_REQ_ADDR, I_REQ_WDATA}),
    .o_out_valid(f_valid),
    .i_out_ready(pop),
    .o_out_data(f_data)
  );

  assign {f_kind, f_wide, f_addr, f_wdata} = f_data;
  assign p = {r.stage, r.ph};
  assign slot_end = (r.st == emb_pkg::EMB_SLOT && p == `EMB_SLOT_LAST) ||
                    (r.st == emb_pkg::EMB_DATA && p == `EMB_DATA_LAST) ||
                    (r.st == emb_pkg::EMB_VERIFY);
  assign pop = slot_end && f_valid && !I_VERIFY_MODE && !r.core_rst;

  always_comb begin
    n = r;
    alt = 8'hFF;
    n.p0_q1 = I_MUXED_ADDR_DATA_PORT;
    n.p0_q2 = r.p0_q1;
    n.p1_q1 = I_GENERAL_PORT_ONE;
    n.p1_q2 = r.p1_q1;
    n.p2_q1 = I_HIGH_ADDRESS_PORT;
    n.p2_q2 = r.p2_q1;
    n.p3_q1 = I_ALTERNATE_FUNCTION_PORT;
    n.p3_q2 = r.p3_q1;
    n.ea_q1 = I_EXTERNAL_FETCH_SELECT_N;
    n.ea_q2 = r.ea_q1;
    n.rp_q1 = I_RESET_PIN;
    n.rp_q2 = r.rp_q1;
    n.resp_v = 1'b0;
    // State sequencing advances on every second oscillator period.
    n.ph = ~r.ph;
    if (r.ph) begin
      n.stage = r.stage + 3'h1;
    end
    if (!r.rp_q2) begin
      n.rst_cnt = 5'h00;
      n.core_rst = 1'b0;
    end else if (r.rst_cnt == 5'(`EMB_RST_CYCLES - 1)) begin
      n.core_rst = 1'b1;
    end else begin
      n.rst_cnt = r.rst_cnt + 5'h01;
    end
    if (r.st == emb_pkg::EMB_SLOT && r.busy && p == `EMB_FETCH_SAMPLE) begin
      n.resp_v = 1'b1;
      n.resp_d = r.ext ? r.p0_q2 : I_ROM_DATA;
      n.resp_ext = r.ext;
    end
    if (r.st == emb_pkg::EMB_DATA && p == `EMB_READ_SAMPLE) begin
      n.resp_v = 1'b1;
      n.resp_d = (r.kind == `EMB_KIND_READ) ? r.p0_q2 : r.wdata;
      n.resp_ext = 1'b1;
    end
    if (slot_end) begin
      n.ph = 1'b0;
      n.stage = 3'h0;
      n.busy = 1'b0;
      n.st = emb_pkg::EMB_SLOT;
      if (I_VERIFY_MODE) begin
        n.st = emb_pkg::EMB_VERIFY;
      end else if (pop) begin
        n.busy = 1'b1;
        n.kind = f_kind;
        n.wide = f_wide;
        n.addr = f_addr;
        n.wdata = f_wdata;
        n.ext = (f_kind != `EMB_KIND_FETCH) || !r.ea_q2 || (f_addr >= `EMB_INT_LIMIT);
        n.st = (f_kind == `EMB_KIND_FETCH) ? emb_pkg::EMB_SLOT : emb_pkg::EMB_DATA;
      end
    end
    // Default pin roles: port zero open drain, the others quasi-bidirectional.
    n.ale = 1'b0;
    n.program_store_strobe_n_n = 1'b1;
    n.p0_o = 8'h00;
    n.p0_oe = quasi_oe(I_P0_LATCH);
    n.p1_o = I_P1_LATCH;
    n.p1_oe = quasi_oe(I_P1_LATCH);
    n.p2_o = I_P2_LATCH;
    n.p2_oe = quasi_oe(I_P2_LATCH);
    case (r.st)
      emb_pkg::EMB_SLOT: begin
        n.ale = (p == `EMB_ALE_P);
        if (r.busy && r.ext) begin
          n.p2_o = r.addr[15:8];
          n.p2_oe = 8'hFF;
          if (p <= `EMB_ADDR_LAST) begin
            n.p0_o = r.addr[7:0];
            n.p0_oe = 8'hFF;
          end else begin
            n.p0_oe = 8'h00;
          end
          n.program_store_strobe_n_n = !in_win(p, `EMB_PROGRAM_STORE_STROBE_N_FIRST, `EMB_PROGRAM_STORE_STROBE_N_LAST);
        end
      end
      emb_pkg::EMB_DATA: begin
        n.ale = (p == `EMB_ALE_P);
        if (r.wide) begin
          n.p2_o = r.addr[15:8];
          n.p2_oe = 8'hFF;
        end
        if (p <= `EMB_ADDR_LAST) begin
          n.p0_o = r.addr[7:0];
          n.p0_oe = 8'hFF;
        end else if (r.kind == `EMB_KIND_WRITE &&
                     in_win(p, `EMB_WDATA_FIRST, `EMB_WDATA_LAST)) begin
          n.p0_o = r.wdata;
          n.p0_oe = 8'hFF;
        end else begin
          n.p0_oe = 8'h00;
        end
        if (in_win(p, `EMB_STB_FIRST, `EMB_STB_LAST)) begin
          alt[`EMB_P3_WR] = (r.kind != `EMB_KIND_WRITE);
          alt[`EMB_P3_RD] = (r.kind != `EMB_KIND_READ);
        end
      end
      emb_pkg::EMB_VERIFY: begin
        n.p0_o = 8'h00;
        n.p0_oe = quasi_oe(I_VERIFY_CODE);
      end
      default: begin
        n.st = emb_pkg::EMB_SLOT;
      end
    endcase
    alt[`EMB_P3_TXD] = I_SERIAL_TXD;
    p3_val = I_P3_LATCH & alt;
    n.p3_o = p3_val;
    n.p3_oe = quasi_oe(p3_val);
    if (r.core_rst) begin
      n.busy = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      r <= '0;
      r.st <= emb_pkg::EMB_SLOT;
      r.program_store_strobe_n_n <= 1'b1;
    end else if (I_CLK_EN) begin
      r <= n;
    end
  end

  assign O_RESP_VALID = r.resp_v;
  assign O_RESP_DATA = r.resp_d;
  assign O_RESP_EXTERNAL = r.resp_ext;
  assign O_VERIFY_ADDR = r.p1_q2;
  assign O_ADDRESS_LATCH_STROBE = r.ale;
  assign O_PROGRAM_STORE_STROBE_N = r.program_store_strobe_n_n;
  assign O_CORE_RESET = r.core_rst;
  assign O_MUXED_ADDR_DATA_PORT = r.p0_o;
  assign O_MUXED_ADDR_DATA_PORT_OE = r.p0_oe;
  assign O_GENERAL_PORT_ONE = r.p1_o;
  assign O_GENERAL_PORT_ONE_OE = r.p1_oe;
  assign O_HIGH_ADDRESS_PORT = r.p2_o;
  assign O_HIGH_ADDRESS_PORT_OE = r.p2_oe;
  assign O_ALTERNATE_FUNCTION_PORT = r.p3_o;
  assign O_ALTERNATE_FUNCTION_PORT_OE = r.p3_oe;
  assign O_P0_IN = r.p0_q2;
  assign O_P1_IN = r.p1_q2;
  assign O_P2_IN = r.p2_q2;
  assign O_P3_IN = r.p3_q2;
  assign O_SERIAL_RXD = r.p3_q2[`EMB_P3_RXD];
  assign O_EXTERNAL_IRQ_ZERO_N = r.p3_q2[`EMB_P3_IRQ0];
  assign O_EXTERNAL_IRQ_ONE_N = r.p3_q2[`EMB_P3_IRQ1];
  assign O_COUNTER_ZERO_INPUT = r.p3_q2[`EMB_P3_CNT0];
  assign O_COUNTER_ONE_INPUT = r.p3_q2[`EMB_P3_CNT1];

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N || !I_CLK_EN || I_VERIFY_MODE);

  sequence ale_one_slot;
    O_ADDRESS_LATCH_STROBE ##1 !O_ADDRESS_LATCH_STROBE [*5] ##1 O_ADDRESS_LATCH_STROBE;
  endsequence

  sequence data_quiet;
    !O_ADDRESS_LATCH_STROBE && O_PROGRAM_STORE_STROBE_N;
  endsequence

  ale_period_a: assert property ((r.st == emb_pkg::EMB_SLOT && p == `EMB_ALE_P) |=> ale_one_slot)
    else $error("address strobe not every six periods");
  ale_data_skip_a: assert property ((r.st == emb_pkg::EMB_DATA && p >= 4'h2) |=> data_quiet)
    else $error("strobe active during data access second half");
  program_store_strobe_n_internal_a: assert property ($fell(O_PROGRAM_STORE_STROBE_N) |-> $past(r.ext))
    else $error("program strobe during internal fetch");
  program_store_strobe_n_width_a: assert property ($fell(O_PROGRAM_STORE_STROBE_N) |->
                                 !O_PROGRAM_STORE_STROBE_N [*3] ##1 O_PROGRAM_STORE_STROBE_N)
    else $error("program strobe width wrong");
  internal_fetch_a: assert property ((pop && f_kind == `EMB_KIND_FETCH) |=>
                                     r.ext == (!$past(r.ea_q2) ||
                                               $past(f_addr) >= `EMB_INT_LIMIT))
    else $error("fetch source selection wrong");
  p2_narrow_a: assert property ((r.st == emb_pkg::EMB_DATA && !r.wide) |=>
                                O_HIGH_ADDRESS_PORT == $past(I_P2_LATCH))
    else $error("port two not showing its latch");
  p2_wide_a: assert property ((r.st == emb_pkg::EMB_DATA && r.wide) |=>
                              (O_HIGH_ADDRESS_PORT == $past(r.addr[15:8])) &&
                              (O_HIGH_ADDRESS_PORT_OE == 8'hFF))
    else $error("port two not showing high address");
  p3_latch_a: assert property (!$past(I_P3_LATCH[`EMB_P3_RD]) |->
                               !O_ALTERNATE_FUNCTION_PORT[`EMB_P3_RD])
    else $error("zero latch did not force pin low");
  write_drive_a: assert property ((r.st == emb_pkg::EMB_DATA && r.kind == `EMB_KIND_WRITE &&
                                   !O_ALTERNATE_FUNCTION_PORT[`EMB_P3_WR] &&
                                   $past(I_P3_LATCH[`EMB_P3_WR])) |->
                                  O_MUXED_ADDR_DATA_PORT_OE == 8'hFF)
    else $error("port zero not driven under write strobe");
  reset_len_a: assert property ($rose(O_CORE_RESET) |->
                                $past(r.rst_cnt) == 5'(`EMB_RST_CYCLES - 1))
    else $error("core reset after wrong hold time");
  divider_a: assert property ((!slot_end && !r.core_rst) |=> r.ph != $past(r.ph))
    else $error("divide by two stage did not toggle");
endmodule

//--- hw/emb_fifo.sv
`timescale 1ns/1ps
module emb_fifo #(
  parameter int W = 27,
  parameter int D = 8
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } emb_fifo_regs_t;

  emb_fifo_regs_t r;
  emb_fifo_regs_t n;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction

  assign o_in_ready = (r.count != (AW + 1)'(D));
  assign o_out_valid = (r.count != '0);
  assign o_out_data = r.mem[r.rptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wptr] = i_in_data;
      n.wptr = bump(r.wptr);
    end
    if (pop) begin
      n.rptr = bump(r.rptr);
    end
    if (push && !pop) begin
      n.count = r.count + (AW + 1)'(1);
    end else if (pop && !push) begin
      n.count = r.count - (AW + 1)'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r <= '0;
    end else if (i_clk_en) begin
      r <= n;
    end
  end
endmodule

//--- hw/emb_map.svh
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH

// Oscillator periods and machine cycle.
`define EMB_REF_CLK_NS 40
`define EMB_OSC_PER_MCYCLE 12
`define EMB_RST_MCYCLES 2
`define EMB_RST_CYCLES (`EMB_RST_MCYCLES * `EMB_OSC_PER_MCYCLE)

// Period index inside a fetch slot (six periods) and a data cycle (twelve periods).
`define EMB_SLOT_LAST 4'h5
`define EMB_DATA_LAST 4'hB
`define EMB_ALE_P 4'h0
`define EMB_ADDR_LAST 4'h1
`define EMB_PROGRAM_STORE_STROBE_N_FIRST 4'h2
`define EMB_PROGRAM_STORE_STROBE_N_LAST 4'h4
`define EMB_FETCH_SAMPLE 4'h5
`define EMB_WDATA_FIRST 4'h2
`define EMB_WDATA_LAST 4'h9
`define EMB_STB_FIRST 4'h3
`define EMB_STB_LAST 4'h8
`define EMB_READ_SAMPLE 4'h9

// Program counter bound for internal code.
`define EMB_INT_LIMIT 16'h1000

// Request kinds.
`define EMB_KIND_FETCH 2'h0
`define EMB_KIND_READ 2'h1
`define EMB_KIND_WRITE 2'h2

// Alternate function port bit positions.
`define EMB_P3_RXD 0
`define EMB_P3_TXD 1
`define EMB_P3_IRQ0 2
`define EMB_P3_IRQ1 3
`define EMB_P3_CNT0 4
`define EMB_P3_CNT1 5
`define EMB_P3_WR 6
`define EMB_P3_RD 7

// Request FIFO.
`define EMB_FIFO_DEPTH 8
`define EMB_REQ_W 27

`endif

//--- hw/emb_pkg.sv
package emb_pkg;

  typedef enum logic [2:0] {
    EMB_SLOT = 3'h1,
    EMB_DATA = 3'h2,
    EMB_VERIFY = 3'h4
  } emb_state_t;

endpackage

//--- sim/emb_bus_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module emb_bus_bench;
  logic I_REF_CLK, I_RST_N, I_CLK_EN, I_REQ_VALID, O_REQ_READY, I_REQ_WIDE, O_RESP_VALID;
  logic O_RESP_EXTERNAL, I_SERIAL_TXD, I_VERIFY_MODE, I_RESET_PIN, I_EXTERNAL_FETCH_SELECT_N;
  logic O_ADDRESS_LATCH_STROBE, O_PROGRAM_STORE_STROBE_N, O_CORE_RESET, O_SERIAL_RXD;
  logic O_EXTERNAL_IRQ_ZERO_N, O_EXTERNAL_IRQ_ONE_N, O_COUNTER_ZERO_INPUT, O_COUNTER_ONE_INPUT;
  logic [1:0] I_REQ_KIND;
  logic [15:0] I_REQ_ADDR;
  logic [7:0] I_REQ_WDATA, I_ROM_DATA, O_RESP_DATA, I_VERIFY_CODE, O_VERIFY_ADDR;
  logic [7:0] I_P0_LATCH, I_P1_LATCH, I_P2_LATCH, I_P3_LATCH, O_P0_IN, O_P1_IN, O_P2_IN, O_P3_IN;
  logic [7:0] I_MUXED_ADDR_DATA_PORT, O_MUXED_ADDR_DATA_PORT, O_MUXED_ADDR_DATA_PORT_OE;
  logic [7:0] I_GENERAL_PORT_ONE, O_GENERAL_PORT_ONE, O_GENERAL_PORT_ONE_OE;
  logic [7:0] I_HIGH_ADDRESS_PORT, O_HIGH_ADDRESS_PORT, O_HIGH_ADDRESS_PORT_OE;
  logic [7:0] I_ALTERNATE_FUNCTION_PORT, O_ALTERNATE_FUNCTION_PORT, O_ALTERNATE_FUNCTION_PORT_OE;
  logic [7:0] ext_p1, ext_p3;
  logic [9:0] expq [$];
  logic [9:0] e;
  int num_errors = 0;
  int n_tests = 0;
  int ale_cnt, program_store_strobe_n_cnt;

  emb_bus emb_bus_i (.*);
  emb_ext_mem emb_ext_mem_i (
    .i_clk(I_REF_CLK),
    .i_ale(O_ADDRESS_LATCH_STROBE),
    .i_program_store_strobe_n_n(O_PROGRAM_STORE_STROBE_N),
    .i_rd_n(I_ALTERNATE_FUNCTION_PORT[7]),
    .i_wr_n(I_ALTERNATE_FUNCTION_PORT[6]),
    .i_p0_out(O_MUXED_ADDR_DATA_PORT),
    .i_p0_oe(O_MUXED_ADDR_DATA_PORT_OE),
    .i_p2_pin(I_HIGH_ADDRESS_PORT),
    .o_p0_pin(I_MUXED_ADDR_DATA_PORT)
  );

  // Undriven bits of ports one to three sit on weak pullups or outside drivers.
  assign I_GENERAL_PORT_ONE = (O_GENERAL_PORT_ONE_OE & O_GENERAL_PORT_ONE)
                              | (~O_GENERAL_PORT_ONE_OE & ext_p1);
  assign I_HIGH_ADDRESS_PORT = (O_HIGH_ADDRESS_PORT_OE & O_HIGH_ADDRESS_PORT)
                               | ~O_HIGH_ADDRESS_PORT_OE;
  assign I_ALTERNATE_FUNCTION_PORT = (O_ALTERNATE_FUNCTION_PORT_OE & O_ALTERNATE_FUNCTION_PORT)
                                     | (~O_ALTERNATE_FUNCTION_PORT_OE & ext_p3);

  always #20 I_REF_CLK = ~I_REF_CLK;

  // Every answer is matched in order against the expected queue.
  always @(negedge I_REF_CLK) begin
    if (O_ADDRESS_LATCH_STROBE === 1'b1) ale_cnt++;
    if (O_PROGRAM_STORE_STROBE_N === 1'b0) program_store_strobe_n_cnt++;
    if (O_RESP_VALID === 1'b1) begin
      if (expq.size() == 0) begin
        `CHK(1'b1, 1'b0);
      end else begin
        e = expq.pop_front();
        `CHK(O_RESP_DATA, e[7:0]);
        if (e[9]) `CHK(O_RESP_EXTERNAL, e[8]);
      end
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge I_REF_CLK);
    #1;
  endtask

  // Holds valid and its fields until an edge with ready high takes them.
  task automatic req(input logic [1:0] k, input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic [9:0] x);
    int n;
    n = 0;
    expq.push_back(x);
    I_REQ_VALID = 1'b1;
    I_REQ_KIND = k;
    I_REQ_WIDE = w;
    I_REQ_ADDR = a;
    I_REQ_WDATA = d;
    while (O_REQ_READY !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    cyc(1);
  endtask

  task automatic drain();
    int n;
    I_REQ_VALID = 1'b0;
    n = 0;
    while (expq.size() != 0 && n < 2000) begin
      cyc(1);
      n++;
    end
    `CHK(expq.size(), 0);
  endtask

  task automatic t_idle();
    cyc(6);
    ale_cnt = 0;
    program_store_strobe_n_cnt = 0;
    cyc(60);
    `CHK(ale_cnt, 10);
    `CHK(program_store_strobe_n_cnt, 0);
    $display("test idle done");
  endtask

  task automatic t_fetch();
    I_EXTERNAL_FETCH_SELECT_N = 1'b0;
    cyc(4);
    program_store_strobe_n_cnt = 0;
    req(2'h0, 1'b0, 16'h0234, 8'h00, {2'h3, 8'hF5});
    drain();
    `CHK(program_store_strobe_n_cnt, 3);
    I_EXTERNAL_FETCH_SELECT_N = 1'b1;
    cyc(4);
    req(2'h0, 1'b0, 16'h0100, 8'h00, {2'h2, 8'h9D});
    req(2'h0, 1'b0, 16'h1234, 8'h00, {2'h3, 8'hE5});
    drain();
    `CHK(program_store_strobe_n_cnt, 6);
    $display("test fetch done");
  endtask

  task automatic t_data();
    program_store_strobe_n_cnt = 0;
    req(2'h2, 1'b1, 16'h4321, 8'hA5, {2'h0, 8'hA5});
    req(2'h1, 1'b1, 16'h4321, 8'h00, {2'h3, 8'hA5});
    req(2'h1, 1'b0, 16'h0021, 8'h00, {2'h3, 8'hA5});
    req(2'h1, 1'b1, 16'h0021, 8'h00, {2'h3, 8'hEE});
    drain();
    `CHK(program_store_strobe_n_cnt, 0);
    $display("test data done");
  endtask

  task automatic t_ports();
    ext_p1 = 8'h5A;
    cyc(5);
    `CHK(O_P1_IN, 8'h5A);
    I_P1_LATCH = 8'h0F;
    ext_p1 = 8'hFF;
    cyc(5);
    `CHK(O_P1_IN, 8'h0F);
    I_P3_LATCH = 8'h7B;
    ext_p3 = 8'hF6;
    cyc(5);
    `CHK(O_EXTERNAL_IRQ_ZERO_N, 1'b0);
    `CHK(O_EXTERNAL_IRQ_ONE_N, 1'b0);
    `CHK(O_SERIAL_RXD, 1'b0);
    `CHK(O_COUNTER_ONE_INPUT, 1'b1);
    `CHK(O_COUNTER_ZERO_INPUT, 1'b1);
    `CHK(O_P2_IN, 8'h43);
    `CHK(O_P3_IN[7], 1'b0);
    I_P3_LATCH = 8'hFF;
    ext_p3 = 8'hFF;
    I_P1_LATCH = 8'hFF;
    cyc(5);
    $display("test ports done");
  endtask

  task automatic t_reset_pin();
    I_RESET_PIN = 1'b1;
    cyc(20);
    `CHK(O_CORE_RESET, 1'b0);
    cyc(10);
    `CHK(O_CORE_RESET, 1'b1);
    I_RESET_PIN = 1'b0;
    cyc(6);
    `CHK(O_CORE_RESET, 1'b0);
    $display("test reset pin done");
  endtask

  task automatic t_verify_queue();
    logic [15:0] a;
    I_VERIFY_MODE = 1'b1;
    I_VERIFY_CODE = 8'h3C;
    ext_p1 = 8'h77;
    cyc(14);
    `CHK(O_VERIFY_ADDR, 8'h77);
    `CHK(O_MUXED_ADDR_DATA_PORT_OE, 8'hC3);
    `CHK(O_MUXED_ADDR_DATA_PORT, 8'h00);
    for (int i = 0; i < 8; i++) begin
      a = 16'h2000 + 16'(i);
      req(2'h0, 1'b0, a, 8'h00, {2'h3, a[7:0] ^ a[15:8] ^ 8'hC3});
    end
    `CHK(O_REQ_READY, 1'b0);
    I_REQ_VALID = 1'b0;
    I_VERIFY_MODE = 1'b0;
    cyc(1);
    drain();
    $display("test verify and queue done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(40 * 6000);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    I_REF_CLK = 1'b0;
    I_RST_N = 1'b0;
    I_CLK_EN = 1'b1;
    I_SERIAL_TXD = 1'b1;
    I_ROM_DATA = 8'h9D;
    {I_REQ_VALID, I_REQ_KIND, I_REQ_WIDE, I_REQ_ADDR, I_REQ_WDATA} = '0;
    {I_VERIFY_MODE, I_RESET_PIN, I_VERIFY_CODE} = '0;
    I_EXTERNAL_FETCH_SELECT_N = 1'b1;
    I_P0_LATCH = 8'hFF;
    I_P1_LATCH = 8'hFF;
    I_P2_LATCH = 8'h43;
    I_P3_LATCH = 8'hFF;
    ext_p1 = 8'hFF;
    ext_p3 = 8'hFF;
    ale_cnt = 0;
    program_store_strobe_n_cnt = 0;
    cyc(3);
    I_RST_N = 1'b1;
    t_idle();
    t_fetch();
    t_data();
    t_ports();
    t_reset_pin();
    t_verify_queue();
    final_report();
  end
endmodule

//--- sim/emb_ext_mem.sv
`timescale 1ns/1ps
module emb_ext_mem (
  // Bus strobes
  input wire logic i_clk,
  input wire logic i_ale,
  input wire logic i_program_store_strobe_n_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  // Bus lines
  input wire logic [7:0] i_p0_out,
  input wire logic [7:0] i_p0_oe,
  input wire logic [7:0] i_p2_pin,
  output logic [7:0] o_p0_pin
);
  logic [7:0] lo_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic [7:0] dmem [0:65535];
  logic [15:0] addr;
  logic [7:0] mem_d;
  logic mem_en;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      dmem[i] = 8'hEE;
    end
  end
  assign addr = {i_p2_pin, lo_r};
  // Code bytes are a fixed function of the address: its two bytes XORed with C3.
  assign mem_d = !i_program_store_strobe_n_n ? (addr[7:0] ^ addr[15:8] ^ 8'hC3) : dmem[addr];
  assign mem_en = !i_program_store_strobe_n_n || !i_rd_n;
  // A floating bus shows the inverse of its last level, never a stale copy.
  assign o_p0_pin = (i_p0_oe & i_p0_out) | (~i_p0_oe & (mem_en ? mem_d : ~last_r));
  always @(posedge i_clk) begin
    last_r <= o_p0_pin;
    if (i_ale) begin
      lo_r <= o_p0_pin;
    end
    if (!i_wr_n) begin
      dmem[addr] <= o_p0_pin;
    end
  end
endmodule
